// file: src/hspg_top.sv
// What this block does
// R1: mode 0: short held 16.3 us shuts driver down and raises the interrupt.
// R2: release timer off: shutdown flag clears only after interrupt is cleared.
// R3: release timer on: flag clears 1630 us after the short goes away.
// R4: host software clears the interrupt; hardware never clears it itself.
// R5: mode 1: short powers driver down at once, no debounce, no interrupt.
// R6: two-bit current limit field, 00 = 115 mA at reset, 11 = 155 mA.
// R7: two-bit P and N driver bias fields, 00 normal at reset, 11 lower.
// R8: input charge bits act only with charge enable; bit0 pos, bit1 neg.
// R9: four-bit mode fields per side; bit 2 no function; reset zero.
// R10: left gain in 1 dB steps, 0x00 = -1 dB at reset, 0x25 = 36 dB.
// R11: lock adjust, loop trim and trim code reset to zero.
// R12: release timer enable selects timer release, reset disabled.
// R13: writing 1 to the clear bit resets the interrupt; reads back 0.
// R14: right gain coded like left, reset 0x00, top 0x25.
// R15: debounce and release counters restart when the short toggles.
// R16: shutdown flag holds driver off while set and is readable.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module hspg_top #(
    parameter int RELEASE_CYCLES = hspg_pkg::RELEASE_CYCLES
) (
    ref_clk,
    rst_n,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hreadyout,
    hrdata,
    hresp,
    short_detect,
    hs_driver_shutdown,
    irq,
    emergency_shutdown_flag,
    analog_cfg
);
    input wire logic ref_clk;
    input wire logic rst_n;
    input wire logic hsel;
    input wire logic [31:0] haddr;
    input wire logic [1:0] htrans;
    input wire logic hwrite;
    input wire logic [2:0] hsize;
    input wire logic [31:0] hwdata;
    input wire logic hready;
    output logic hreadyout;
    output logic [31:0] hrdata;
    output logic hresp;
    input wire logic short_detect;
    output logic hs_driver_shutdown;
    output logic irq;
    output logic emergency_shutdown_flag;
    output hspg_pkg::hspg_analog_cfg_type analog_cfg;

    localparam logic [hspg_pkg::CNT_W-1:0] DEB_LAST =
        hspg_pkg::CNT_W'(hspg_pkg::DEBOUNCE_CYCLES - 1);
    localparam logic [hspg_pkg::CNT_W-1:0] REL_LAST =
        hspg_pkg::CNT_W'(RELEASE_CYCLES - 1);
    localparam logic [hspg_pkg::CNT_W-1:0] CNT_ONE =
        hspg_pkg::CNT_W'(1);

    typedef struct packed {
        logic [15:0] drv_ctl;
        logic [15:0] fe_cfg;
        logic [15:0] gain;
        hspg_pkg::hspg_prot_type pstate;
        logic [hspg_pkg::CNT_W-1:0] cnt;
        logic irq;
        logic clr_pulse;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
    } hspg_state_type;

    hspg_state_type st_reg;
    hspg_state_type st_next;
    hspg_pkg::hspg_ahb_req_type req;
    logic short_now;

    // ********************************************************
    // short input synchroniser
    // ********************************************************
    hspg_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in(short_detect),
        .level_out(short_now)
    );

    assign req = '{sel: hsel, addr: haddr, trans: htrans, write: hwrite,
                   size: hsize, ready: hready};

    // ********************************************************
    // helpers
    // ********************************************************
    function automatic logic [5:0] clamp_gain(input logic [5:0] g);
        // codes above the top step saturate rather than alias
        return (g > hspg_pkg::GAIN_MAX) ? hspg_pkg::GAIN_MAX : g;
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        return idx == hspg_pkg::IDX_STATUS ||
               idx == hspg_pkg::IDX_DRV_PROTECT ||
               idx == hspg_pkg::IDX_FE_CFG ||
               idx == hspg_pkg::IDX_GAIN;
    endfunction

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        logic auto_sel;
        logic timer_en;
        logic addr_ok;
        logic [7:0] idx;
        logic [15:0] rd16;
        logic [5:0] gl;
        logic [5:0] gr;
        auto_sel = 1'b0;
        timer_en = 1'b0;
        addr_ok = 1'b0;
        idx = 8'h00;
        rd16 = 16'h0000;
        gl = 6'h00;
        gr = 6'h00;
        st_next = st_reg;
        st_next.clr_pulse = 1'b0;
        st_next.wr_pend = 1'b0;

        // write data phase
        if (st_reg.wr_pend) begin
            case (st_reg.wr_idx)
                hspg_pkg::IDX_DRV_PROTECT: begin
                    st_next.drv_ctl = hwdata[15:0] & hspg_pkg::DRV_WMASK;
                    st_next.clr_pulse =
                        hwdata[hspg_pkg::CLR_EVENT_BIT]; // see R13
                end
                hspg_pkg::IDX_FE_CFG: begin
                    st_next.fe_cfg = hwdata[15:0];
                end
                hspg_pkg::IDX_GAIN: begin
                    gl = clamp_gain(hwdata[hspg_pkg::LEFT_GAIN_LSB +:
                                           hspg_pkg::GAIN_W]); // see R10
                    gr = clamp_gain(hwdata[hspg_pkg::RIGHT_GAIN_LSB +:
                                           hspg_pkg::GAIN_W]); // see R14
                    st_next.gain = 16'h0000;
                    st_next.gain[hspg_pkg::LEFT_GAIN_LSB +:
                                 hspg_pkg::GAIN_W] = gl;
                    st_next.gain[hspg_pkg::RIGHT_GAIN_LSB +:
                                 hspg_pkg::GAIN_W] = gr;
                end
                default: begin
                    st_next.wr_idx = st_reg.wr_idx;
                end
            endcase
        end

        auto_sel = st_reg.drv_ctl[hspg_pkg::AUTO_SEL_BIT];
        timer_en = st_reg.drv_ctl[hspg_pkg::REL_TIMER_BIT]; // see R12

        // clear pulse first, so a trip in the same cycle wins
        if (st_reg.clr_pulse) begin
            st_next.irq = 1'b0; // see R13
        end

        // protection state machine
        case (st_reg.pstate)
            hspg_pkg::PS_IDLE: begin
                st_next.cnt = '0;
                if (short_now && !auto_sel) begin
                    st_next.pstate = hspg_pkg::PS_DEBOUNCE; // see R1
                end
            end
            hspg_pkg::PS_DEBOUNCE: begin
                if (!short_now || auto_sel) begin
                    // short went away early: start over
                    st_next.pstate = hspg_pkg::PS_IDLE; // see R15
                    st_next.cnt = '0;
                end else if (st_reg.cnt == DEB_LAST) begin
                    st_next.pstate = hspg_pkg::PS_TRIPPED; // see R1
                    st_next.irq = 1'b1; // see R1
                    st_next.cnt = '0;
                end else begin
                    st_next.cnt = st_reg.cnt + CNT_ONE;
                end
            end
            hspg_pkg::PS_TRIPPED: begin
                st_next.cnt = '0;
                if (timer_en) begin
                    if (!short_now) begin
                        st_next.pstate = hspg_pkg::PS_RELEASE; // see R3
                    end
                end else if (!st_reg.irq) begin
                    // interrupt only ever cleared by software
                    st_next.pstate = hspg_pkg::PS_IDLE; // see R2, R4
                end
            end
            hspg_pkg::PS_RELEASE: begin
                if (!timer_en) begin
                    st_next.pstate = hspg_pkg::PS_TRIPPED; // see R2
                    st_next.cnt = '0;
                end else if (short_now) begin
                    st_next.pstate = hspg_pkg::PS_TRIPPED; // see R15
                    st_next.cnt = '0;
                end else if (st_reg.cnt == REL_LAST) begin
                    // interrupt left alone on release
                    st_next.pstate = hspg_pkg::PS_IDLE; // see R3, R4
                    st_next.cnt = '0;
                end else begin
                    st_next.cnt = st_reg.cnt + CNT_ONE;
                end
            end
            default: begin
                st_next.pstate = hspg_pkg::PS_IDLE;
                st_next.cnt = '0;
            end
        endcase

        // address phase
        idx = req.addr[9:2];
        addr_ok = (req.addr[31:10] == 22'h00_0000) &&
                  (req.addr[1:0] == 2'b00) && mapped(idx);
        if (req.sel && req.ready && req.trans == hspg_pkg::HTRANS_NONSEQ) begin
            if (req.write) begin
                st_next.wr_pend = addr_ok;
                st_next.wr_idx = idx;
            end else begin
                // read sees a write finishing in this same cycle
                case (idx)
                    hspg_pkg::IDX_STATUS: begin
                        rd16[hspg_pkg::ST_FLAG_BIT] =
                            st_reg.pstate == hspg_pkg::PS_TRIPPED ||
                            st_reg.pstate == hspg_pkg::PS_RELEASE; // see R16
                        rd16[hspg_pkg::ST_IRQ_BIT] = st_reg.irq;
                        rd16[hspg_pkg::ST_SHORT_BIT] = short_now;
                    end
                    hspg_pkg::IDX_DRV_PROTECT: rd16 = st_next.drv_ctl;
                    hspg_pkg::IDX_FE_CFG: rd16 = st_next.fe_cfg;
                    hspg_pkg::IDX_GAIN: rd16 = st_next.gain;
                    default: rd16 = 16'h0000;
                endcase
                if (!addr_ok) begin
                    rd16 = 16'h0000;
                end
                st_next.rdata = {16'h0000, rd16};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_reg.drv_ctl <= hspg_pkg::RST_DRV_PROTECT; // see R6, R7, R12
            st_reg.fe_cfg <= hspg_pkg::RST_FE_CFG; // see R9, R11
            st_reg.gain <= hspg_pkg::RST_GAIN; // see R10, R14
            st_reg.pstate <= hspg_pkg::PS_IDLE;
            st_reg.cnt <= '0;
            st_reg.irq <= 1'b0;
            st_reg.clr_pulse <= 1'b0;
            st_reg.wr_pend <= 1'b0;
            st_reg.wr_idx <= 8'h00;
            st_reg.rdata <= 32'h0000_0000;
        end else begin
            st_reg <= st_next;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_reg.rdata;
    assign irq = st_reg.irq;
    assign emergency_shutdown_flag =
        st_reg.pstate == hspg_pkg::PS_TRIPPED ||
        st_reg.pstate == hspg_pkg::PS_RELEASE;
    // mode 1 follows the synchronised short with no debounce
    assign hs_driver_shutdown = emergency_shutdown_flag ||
        (st_reg.drv_ctl[hspg_pkg::AUTO_SEL_BIT] && short_now); // see R5, R16

    always_comb begin
        analog_cfg.short_current_limit =
            st_reg.drv_ctl[hspg_pkg::LIMIT_LSB +: 2]; // see R6
        analog_cfg.p_driver_bias_adj =
            st_reg.drv_ctl[hspg_pkg::PBIAS_LSB +: 2]; // see R7
        analog_cfg.n_driver_bias_adj =
            st_reg.drv_ctl[hspg_pkg::NBIAS_LSB +: 2]; // see R7
        analog_cfg.input_vref_charge =
            st_reg.drv_ctl[hspg_pkg::CHARGE_EN_BIT] ?
            st_reg.fe_cfg[hspg_pkg::VREF_CHG_LSB +: 2] : 2'b00; // see R8
        analog_cfg.cm_lock_adj =
            st_reg.fe_cfg[hspg_pkg::CM_LOCK_LSB +: 2]; // see R11
        analog_cfg.loop_current_trim =
            st_reg.fe_cfg[hspg_pkg::LOOP_TRIM_BIT]; // see R11
        analog_cfg.current_trim_code =
            st_reg.fe_cfg[hspg_pkg::TRIM_CODE_LSB +: 3]; // see R11
        analog_cfg.left_frontend_mode =
            st_reg.fe_cfg[hspg_pkg::LEFT_MODE_LSB +: 4];
        analog_cfg.right_frontend_mode =
            st_reg.fe_cfg[hspg_pkg::RIGHT_MODE_LSB +: 4];
        // unused mode bit held low at the analog side
        analog_cfg.left_frontend_mode[hspg_pkg::MODE_NOFUNC_BIT] =
            1'b0; // see R9
        analog_cfg.right_frontend_mode[hspg_pkg::MODE_NOFUNC_BIT] =
            1'b0; // see R9
        analog_cfg.left_input_gain =
            st_reg.gain[hspg_pkg::LEFT_GAIN_LSB +: hspg_pkg::GAIN_W];
        analog_cfg.right_input_gain =
            st_reg.gain[hspg_pkg::RIGHT_GAIN_LSB +: hspg_pkg::GAIN_W];
    end

endmodule

`default_nettype wire

// file: pkg/hspg_pkg.sv
package hspg_pkg;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int DEBOUNCE_NS = 16300;
    localparam int RELEASE_NS = 1630000;
    // least times: round up to whole cycles
    localparam int DEBOUNCE_CYCLES =
        (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_CYCLES =
        (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 14;

    // ********************************************************
    // register indices (byte address is four times the index)
    // ********************************************************
    localparam logic [7:0] IDX_STATUS = 8'h70;
    localparam logic [7:0] IDX_DRV_PROTECT = 8'h76;
    localparam logic [7:0] IDX_FE_CFG = 8'h77;
    localparam logic [7:0] IDX_GAIN = 8'h7e;

    localparam logic [15:0] RST_DRV_PROTECT = 16'h0000;
    localparam logic [15:0] RST_FE_CFG = 16'h0000;
    localparam logic [15:0] RST_GAIN = 16'h0000;

    // ********************************************************
    // driver_protect_control fields
    // ********************************************************
    localparam int CLR_EVENT_BIT = 15;
    localparam int CHARGE_EN_BIT = 14;
    localparam int REL_TIMER_BIT = 13;
    localparam int AUTO_SEL_BIT = 12;
    localparam int LIMIT_LSB = 10;
    localparam int PBIAS_LSB = 8;
    localparam int NBIAS_LSB = 6;
    // clear bit is self-clearing and never stored
    localparam logic [15:0] DRV_WMASK = 16'h7fc0;

    // ********************************************************
    // frontend_amp_config fields
    // ********************************************************
    localparam int VREF_CHG_LSB = 14;
    localparam int CM_LOCK_LSB = 12;
    localparam int LOOP_TRIM_BIT = 11;
    localparam int TRIM_CODE_LSB = 8;
    localparam int LEFT_MODE_LSB = 4;
    localparam int RIGHT_MODE_LSB = 0;
    localparam int MODE_NOFUNC_BIT = 2;

    // ********************************************************
    // input_amp_gain fields
    // ********************************************************
    localparam int GAIN_W = 6;
    localparam int LEFT_GAIN_LSB = 0;
    localparam int RIGHT_GAIN_LSB = 8;
    localparam logic [5:0] GAIN_MAX = 6'h25;

    // status fields
    localparam int ST_FLAG_BIT = 0;
    localparam int ST_IRQ_BIT = 1;
    localparam int ST_SHORT_BIT = 2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [3:0] {
        PS_IDLE = 4'h1,
        PS_DEBOUNCE = 4'h2,
        PS_TRIPPED = 4'h4,
        PS_RELEASE = 4'h8
    } hspg_prot_type;

    typedef struct packed {
        logic [1:0] short_current_limit;
        logic [1:0] p_driver_bias_adj;
        logic [1:0] n_driver_bias_adj;
        logic [1:0] input_vref_charge;
        logic [1:0] cm_lock_adj;
        logic loop_current_trim;
        logic [2:0] current_trim_code;
        logic [3:0] left_frontend_mode;
        logic [3:0] right_frontend_mode;
        logic [5:0] left_input_gain;
        logic [5:0] right_input_gain;
    } hspg_analog_cfg_type;

    typedef struct packed {
        logic sel;
        logic [31:0] addr;
        logic [1:0] trans;
        logic write;
        logic [2:0] size;
        logic ready;
    } hspg_ahb_req_type;

endpackage

// file: src/hspg_sync.sv
`timescale 1ns/1ps
`default_nettype none

module hspg_sync (
    ref_clk,
    rst_n,
    pin_in,
    level_out
);
    input wire logic ref_clk;
    input wire logic rst_n;
    input wire logic pin_in;
    output logic level_out;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } hspg_sync_state_type;

    hspg_sync_state_type st_reg;
    hspg_sync_state_type st_next;

    // s1 feeds only s2; a change counts once s2 and s3 agree
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.level = st_reg.s3;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.level;

endmodule

`default_nettype wire

// file: testbench/hspg_load.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// headset load with its short comparator
// ********************************************************
module hspg_load #(
    parameter int SETTLE_NS = 37
) (
    input wire logic short_cmd,
    output logic short_detect
);
    // comparator output lands well away from the clock edge
    assign #(SETTLE_NS) short_detect = short_cmd;
endmodule

`default_nettype wire

// file: testbench/hspg_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

module hspg_top_chk #(
    parameter int RELEASE_CYCLES = 16300
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic short_detect,
    input wire logic hs_driver_shutdown,
    input wire logic irq,
    input wire logic emergency_shutdown_flag,
    input wire hspg_pkg::hspg_analog_cfg_type analog_cfg
);
    // ********************************************************
    // shadow of the control bits and raw short run lengths
    // ********************************************************
    localparam logic [31:0] A_DRV = 32'(hspg_pkg::IDX_DRV_PROTECT) << 2;
    logic wr_drv_reg, tmr_reg, auto_reg, clr_hit;
    logic [15:0] hi_reg, lo_reg, rl_reg;

    assign clr_hit = wr_drv_reg && hwdata[15];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_drv_reg <= 1'b0;
            tmr_reg <= 1'b0;
            auto_reg <= 1'b0;
            hi_reg <= 16'h0000;
            lo_reg <= 16'h0000;
            rl_reg <= 16'h0000;
        end else begin
            wr_drv_reg <= hsel && hready && htrans == 2'h2 && hwrite
                && haddr == A_DRV;
            if (wr_drv_reg) begin
                tmr_reg <= hwdata[13];
                auto_reg <= hwdata[12];
            end
            hi_reg <= short_detect ? hi_reg + 16'h0001 : 16'h0000;
            lo_reg <= short_detect ? 16'h0000 : lo_reg + 16'h0001;
            rl_reg <= (tmr_reg && !short_detect) ? rl_reg + 16'h0001
                : 16'h0000;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ********************************************************
    // properties
    // ********************************************************
    a_bus_okay: assert property (hreadyout && !hresp
        && hrdata[31:16] == 16'h0000)
        else $error("bus answer not zero-wait okay");
    a_debounce_min: assert property (
        $rose(emergency_shutdown_flag)
        |-> !auto_reg && hi_reg >= 163)
        else $error("shutdown flag set before debounce ran out");
    a_irq_cause: assert property ($rose(irq)
        |-> emergency_shutdown_flag && !auto_reg)
        else $error("interrupt raised without a debounced trip");
    a_irq_hold: assert property ($fell(irq)
        |-> $past(clr_hit) || $past(clr_hit, 2))
        else $error("interrupt dropped without a clear write");
    a_clear_takes: assert property (clr_hit && hi_reg == 16'h0000
        |-> ##[1:2] !irq)
        else $error("clear write left the interrupt up");
    a_release_early: assert property (
        $fell(emergency_shutdown_flag)
        |-> (tmr_reg ? lo_reg >= RELEASE_CYCLES : !$past(irq)))
        else $error("shutdown flag released too early");
    a_release_bound: assert property (rl_reg > RELEASE_CYCLES + 10
        |-> !emergency_shutdown_flag)
        else $error("timer did not release the shutdown flag");
    a_mode1_fast: assert property (auto_reg && hi_reg >= 8
        |-> hs_driver_shutdown)
        else $error("immediate mode did not shut the driver down");
    a_flag_drv_off: assert property (emergency_shutdown_flag
        |-> hs_driver_shutdown)
        else $error("driver running while shutdown flag set");
    a_shut_cause: assert property (hs_driver_shutdown
        |-> emergency_shutdown_flag || auto_reg)
        else $error("driver shut down without cause");
endmodule

bind hspg_top hspg_top_chk #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_chk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .short_detect(short_detect),
    .hs_driver_shutdown(hs_driver_shutdown),
    .irq(irq),
    .emergency_shutdown_flag(emergency_shutdown_flag),
    .analog_cfg(analog_cfg)
);

`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int REL = 20;
    localparam logic [31:0] A_ST = 32'(hspg_pkg::IDX_STATUS) << 2;
    localparam logic [31:0] A_DRV = 32'(hspg_pkg::IDX_DRV_PROTECT) << 2;
    localparam logic [31:0] A_FE = 32'(hspg_pkg::IDX_FE_CFG) << 2;
    localparam logic [31:0] A_GN = 32'(hspg_pkg::IDX_GAIN) << 2;
    logic ref_clk, rst_n, hsel, hwrite, short_cmd, short_detect;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, hs_driver_shutdown, irq, emergency_shutdown_flag;
    hspg_pkg::hspg_analog_cfg_type analog_cfg;
    logic [5:0] codes [4] = '{6'h00, 6'h01, 6'h25, 6'h3f};
    logic [5:0] e;
    int num_errors = 0;
    int total_checks = 0;

    hspg_top #(.RELEASE_CYCLES(REL)) u_hspg_top (
        .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .short_detect(short_detect),
        .hs_driver_shutdown(hs_driver_shutdown), .irq(irq),
        .emergency_shutdown_flag(emergency_shutdown_flag),
        .analog_cfg(analog_cfg)
    );
    hspg_load u_hspg_load (.short_cmd(short_cmd), .short_detect(short_detect));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ********************************************************
    // bus and check tasks
    // ********************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [15:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, d};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, q);
        chk(36'(q), 36'(exp));
    endtask

    task automatic end_of_test;
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ********************************************************
    // scenarios
    // ********************************************************
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        short_cmd = 1'b0;
        cyc(5);
        rst_n <= 1'b1;
        rdc(A_DRV, 32'h0000_0000);
        rdc(A_FE, 32'h0000_0000);
        rdc(A_GN, 32'h0000_0000);
        rdc(A_ST, 32'h0000_0000);
        chk(36'(analog_cfg), 36'h0_0000_0000);
        // unmapped place: writes vanish and reads give zero
        wr(32'h0000_01e0, 16'hffff);
        rdc(32'h0000_01e0, 32'h0000_0000);
        wr(A_DRV, 16'hffc0);
        rdc(A_DRV, 32'h0000_7fc0);
        wr(A_FE, 16'hffff);
        rdc(A_FE, 32'h0000_ffff);
        chk(36'({analog_cfg.short_current_limit, analog_cfg.p_driver_bias_adj,
            analog_cfg.n_driver_bias_adj}), 36'h3f);
        chk(36'(analog_cfg.input_vref_charge), 36'h3);
        chk(36'({analog_cfg.left_frontend_mode,
            analog_cfg.right_frontend_mode}), 36'hbb);
        chk(36'({analog_cfg.cm_lock_adj, analog_cfg.loop_current_trim,
            analog_cfg.current_trim_code}), 36'h3f);
        wr(A_DRV, 16'h0000);
        cyc(1);
        chk(36'(analog_cfg.input_vref_charge), 36'h0);
        for (int i = 0; i < 4; i++) begin
            e = (codes[i] > 6'h25) ? 6'h25 : codes[i];
            wr(A_GN, {2'b00, codes[i], 2'b00, codes[i]});
            rdc(A_GN, {16'h0000, 2'b00, e, 2'b00, e});
            chk(36'({analog_cfg.left_input_gain,
                analog_cfg.right_input_gain}), 36'({e, e}));
        end
        // debounced trip, release only by clearing the interrupt
        short_cmd <= 1'b1;
        cyc(100);
        short_cmd <= 1'b0;
        cyc(20);
        short_cmd <= 1'b1;
        cyc(150);
        rdc(A_ST, 32'h0000_0004);
        cyc(30);
        rdc(A_ST, 32'h0000_0007);
        chk(36'({irq, hs_driver_shutdown}), 36'h3);
        short_cmd <= 1'b0;
        cyc(50);
        rdc(A_ST, 32'h0000_0003);
        wr(A_DRV, 16'h8000);
        cyc(4);
        rdc(A_ST, 32'h0000_0000);
        chk(36'(hs_driver_shutdown), 36'h0);
        // release by timer, interrupt stays for software
        wr(A_DRV, 16'h2000);
        short_cmd <= 1'b1;
        cyc(180);
        short_cmd <= 1'b0;
        cyc(12);
        rdc(A_ST, 32'h0000_0003);
        cyc(30);
        rdc(A_ST, 32'h0000_0002);
        wr(A_DRV, 16'ha000);
        cyc(4);
        rdc(A_ST, 32'h0000_0000);
        // immediate shutdown with no interrupt
        wr(A_DRV, 16'h1000);
        short_cmd <= 1'b1;
        cyc(8);
        chk(36'({hs_driver_shutdown, irq, emergency_shutdown_flag}),
            36'h4);
        cyc(200);
        rdc(A_ST, 32'h0000_0004);
        short_cmd <= 1'b0;
        cyc(8);
        chk(36'(hs_driver_shutdown), 36'h0);
        end_of_test();
    end

    initial begin
        #400000;
        num_errors++;
        end_of_test();
    end
endmodule

`default_nettype wire
